/* File: logic/dpa_pkg.sv */
// Purpose: Shared constants and state types of the dual parallel port adapter
// Assumes: One 10 MHz clock; all pins synchronous to it
// Notes: Control register layout and register-select codes live here

package dpa_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam real RESET_RECOVERY_US = 1.0;
    localparam int RESET_RECOVERY_CYC = int'((RESET_RECOVERY_US * 1000.0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Register select codes
    // ------------------------------------------------------------
    localparam logic [1:0] RS_FIRST_DATA = 2'h0;
    localparam logic [1:0] RS_FIRST_CTRL = 2'h1;
    localparam logic [1:0] RS_SECOND_DATA = 2'h2;
    localparam logic [1:0] RS_SECOND_CTRL = 2'h3;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CR_INT1_EN = 0;
    localparam int CR_INT1_RISE = 1;
    localparam int CR_DIR_ACCESS = 2;
    localparam int CR_CTL2_B3 = 3;
    localparam int CR_CTL2_B4 = 4;
    localparam int CR_CTL2_OUT = 5;
    localparam int CR_FLAG2 = 6;
    localparam int CR_FLAG1 = 7;
    localparam int CR_RW_BITS = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_CTRL = 6'h00;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic line_prev;
        logic armed;
        logic blocked;
        logic flag;
    } dpa_cell_s;

    typedef struct packed {
        logic [1:0][7:0] outr;
        logic [1:0][7:0] dir;
        logic [1:0][5:0] ctl;
        logic en_prev;
        logic sel_l;
        logic rw_l;
        logic [1:0] rs_l;
        logic [7:0] din_l;
        logic [7:0] dout;
        logic [1:0] c2;
        logic [1:0] c2_pend;
        logic [1:0] desel_seen;
    } dpa_state_s;

endpackage

/* File: logic/dpa_edge_flag.sv */
// Purpose: Edge-sensed interrupt flag for one peripheral control line
// Assumes: Strobe events arrive as one-cycle pulses
// Notes: Set beats clear in the same cycle

`timescale 1ns/1ns

module dpa_edge_flag
    import dpa_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wipe_i,
    input wire logic strobe_fall_i,
    input wire logic desel_fall_i,
    input wire logic line_i,
    input wire logic rise_sel_i,
    input wire logic listen_i,
    input wire logic clear_i,
    output logic flag_o
);

    dpa_cell_s q_r;
    dpa_cell_s q_nxt;
    logic act;
    logic prev_act;
    logic set_ev;

    // ------------------------------------------------------------
    // Edge sense
    // ------------------------------------------------------------
    always_comb begin
        act = rise_sel_i ? line_i : !line_i;
        prev_act = rise_sel_i ? q_r.line_prev : !q_r.line_prev;
        set_ev = listen_i && q_r.armed && !q_r.blocked && act && !prev_act;
        q_nxt = q_r;
        q_nxt.line_prev = line_i;
        if (strobe_fall_i) begin
            q_nxt.armed = !act;
        end
        if (set_ev) begin
            q_nxt.armed = 1'b0;
        end
        if (desel_fall_i) begin
            q_nxt.blocked = 1'b0;
        end
        if (clear_i) begin
            q_nxt.flag = 1'b0;
            q_nxt.blocked = 1'b1;
        end
        if (set_ev) begin
            q_nxt.flag = 1'b1;
        end
        if (wipe_i) begin
            q_nxt = '0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign flag_o = q_r.flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BLOCKED_NO_SET: assert property (@(posedge clock_i) disable iff (rst_i)
        q_r.blocked |=> !$rose(flag_o)) else $error("flag set while blocked after clear");

    AST_SET_NEEDS_ARM: assert property (@(posedge clock_i) disable iff (rst_i)
        !q_r.armed |=> !$rose(flag_o)) else $error("flag set without conditioning strobe");

    AST_CLEAR_WORKS: assert property (@(posedge clock_i) disable iff (rst_i)
        clear_i && !set_ev |=> !flag_o) else $error("flag survived data read");

endmodule // dpa_edge_flag

/* File: logic/dpa_adapter.sv */
// Purpose: Dual 8-bit parallel port adapter with processor pin interface
// Assumes: All pins synchronous to clock_i; enable strobe sampled as a level
// Notes: Strobe edges are detected in the clock domain, no second clock
// Notes on behaviour
// - Selected only when both high chip selects high and low select low.
// - Data bus drivers off except during a selected read.
// - Selected write with read_write low stores bus data on the strobe.
// - Read drives addressed register; drivers on only with selection and strobe.
// - Enable strobe edges are the only timing reference for the bus.
// - Reset pin low zeroes every register bit.
// - Interrupt requests are active-low open drain, pull low or release.
// - Request low when an enabled flag of its port is set.
// - Reading a port's data register clears both its flags.
// - Cleared flag stays blocked until a deselected strobe occurs.
// - Strobe at inactive level conditions edge; active edge then sets flag.
// - Direction bit one makes a line output, zero input.
// - Data read returns current level of input lines.
// - Output lines drive the output register bit value.
// - First port reads the sensed pin level even for outputs.
// - Second port floats input lines and reads outputs from register.
// - First control line is input only with selectable active edge.
// - Flags readable in control register bits seven and six.
// - Control bit two steers data location to data or direction register.
// - Control bits zero to five writable, six and seven read-only flags.
// - Bit zero enables first line request, bit one picks rising edge.
// - Bit five zero makes second line an input, one an output.

`timescale 1ns/1ns

module dpa_adapter
    import dpa_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reset_n_i,
    input wire logic chip_select_high_a_i,
    input wire logic chip_select_high_b_i,
    input wire logic chip_select_low_i,
    input wire logic register_select_low_bit_i,
    input wire logic register_select_high_bit_i,
    input wire logic read_write_i,
    input wire logic enable_i,
    input wire logic [WIDTH-1:0] processor_data_bus_i,
    output logic [WIDTH-1:0] processor_data_bus_o,
    output logic processor_data_bus_oe_n_o,
    output logic irq_port_first_n_o,
    output logic irq_port_first_n_oe_n_o,
    output logic irq_port_second_n_o,
    output logic irq_port_second_n_oe_n_o,
    input wire logic [WIDTH-1:0] first_port_lines_i,
    output logic [WIDTH-1:0] first_port_lines_o,
    output logic [WIDTH-1:0] first_port_lines_oe_n_o,
    input wire logic [WIDTH-1:0] second_port_lines_i,
    output logic [WIDTH-1:0] second_port_lines_o,
    output logic [WIDTH-1:0] second_port_lines_oe_n_o,
    input wire logic first_port_int_input_i,
    input wire logic second_port_int_input_i,
    input wire logic first_port_ctrl_line_i,
    output logic first_port_ctrl_line_o,
    output logic first_port_ctrl_line_oe_n_o,
    input wire logic second_port_ctrl_line_i,
    output logic second_port_ctrl_line_o,
    output logic second_port_ctrl_line_oe_n_o
);

    dpa_state_s q_r;
    dpa_state_s q_nxt;

    logic sel_now;
    logic en_fall;
    logic en_rise;
    logic desel_fall;
    logic wr_ev;
    logic rd_ev;
    logic [1:0] data_rd;
    logic [1:0] data_wr;
    logic [1:0][1:0] flag;
    logic [1:0] int1_in;
    logic [1:0] ctl2_in;
    logic [1:0][7:0] pin_in;
    logic [1:0] irq_req;
    logic [7:0] rd_mux;
    logic [7:0] port_rd;
    logic [1:0] p_sel;

    // ------------------------------------------------------------
    // Selection and strobe edges
    // ------------------------------------------------------------
    // three-way select decode
    assign sel_now = chip_select_high_a_i && chip_select_high_b_i && !chip_select_low_i;
    assign en_fall = q_r.en_prev && !enable_i;
    assign en_rise = !q_r.en_prev && enable_i;
    assign wr_ev = en_fall && q_r.sel_l && !q_r.rw_l;
    assign rd_ev = en_fall && q_r.sel_l && q_r.rw_l;
    assign desel_fall = en_fall && !q_r.sel_l;

    assign int1_in = {second_port_int_input_i, first_port_int_input_i};
    assign ctl2_in = {second_port_ctrl_line_i, first_port_ctrl_line_i};
    assign pin_in = {second_port_lines_i, first_port_lines_i};

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            data_rd[p] = rd_ev && (q_r.rs_l == (p == 0 ? RS_FIRST_DATA : RS_SECOND_DATA))
                         && q_r.ctl[p][CR_DIR_ACCESS];
            data_wr[p] = wr_ev && (q_r.rs_l == (p == 0 ? RS_FIRST_DATA : RS_SECOND_DATA))
                         && q_r.ctl[p][CR_DIR_ACCESS];
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags, two per port
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        dpa_edge_flag u_flag1 (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .wipe_i(!reset_n_i),
            .strobe_fall_i(en_fall),
            .desel_fall_i(desel_fall),
            .line_i(int1_in[p]),
            .rise_sel_i(q_r.ctl[p][CR_INT1_RISE]),
            .listen_i(1'b1),
            .clear_i(data_rd[p]),
            .flag_o(flag[p][1])
        );
        dpa_edge_flag u_flag2 (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .wipe_i(!reset_n_i),
            .strobe_fall_i(en_fall),
            .desel_fall_i(desel_fall),
            .line_i(ctl2_in[p]),
            .rise_sel_i(q_r.ctl[p][CR_CTL2_B4]),
            .listen_i(!q_r.ctl[p][CR_CTL2_OUT]),
            .clear_i(data_rd[p]),
            .flag_o(flag[p][0])
        );
        assign irq_req[p] = (flag[p][1] && q_r.ctl[p][CR_INT1_EN])
                            || (flag[p][0] && q_r.ctl[p][CR_CTL2_B3] && !q_r.ctl[p][CR_CTL2_OUT]);
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always_comb begin
        p_sel = q_r.rs_l;
        port_rd = RST_BYTE;
        rd_mux = RST_BYTE;
        p_sel = {register_select_high_bit_i, register_select_low_bit_i};
        if (register_select_high_bit_i) begin
            port_rd = (q_r.dir[1] & q_r.outr[1]) | (~q_r.dir[1] & pin_in[1]);
        end else begin
            port_rd = pin_in[0];
        end
        unique case (p_sel)
            RS_FIRST_DATA: begin
                rd_mux = q_r.ctl[0][CR_DIR_ACCESS] ? port_rd : q_r.dir[0];
            end
            RS_SECOND_DATA: begin
                rd_mux = q_r.ctl[1][CR_DIR_ACCESS] ? port_rd : q_r.dir[1];
            end
            RS_FIRST_CTRL: begin
                rd_mux = {flag[0][1], flag[0][0], q_r.ctl[0]};
            end
            RS_SECOND_CTRL: begin
                rd_mux = {flag[1][1], flag[1][0], q_r.ctl[1]};
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.en_prev = enable_i;
        if (enable_i) begin
            q_nxt.sel_l = sel_now;
            q_nxt.rw_l = read_write_i;
            q_nxt.rs_l = {register_select_high_bit_i, register_select_low_bit_i};
            q_nxt.din_l = processor_data_bus_i;
            q_nxt.dout = rd_mux;
        end
        if (wr_ev) begin
            unique case (q_r.rs_l)
                RS_FIRST_DATA: begin
                    if (q_r.ctl[0][CR_DIR_ACCESS]) begin
                        q_nxt.outr[0] = q_r.din_l;
                    end else begin
                        q_nxt.dir[0] = q_r.din_l;
                    end
                end
                RS_SECOND_DATA: begin
                    if (q_r.ctl[1][CR_DIR_ACCESS]) begin
                        q_nxt.outr[1] = q_r.din_l;
                    end else begin
                        q_nxt.dir[1] = q_r.din_l;
                    end
                end
                RS_FIRST_CTRL: begin
                    q_nxt.ctl[0] = q_r.din_l[CR_RW_BITS-1:0];
                end
                RS_SECOND_CTRL: begin
                    q_nxt.ctl[1] = q_r.din_l[CR_RW_BITS-1:0];
                end
            endcase
        end
        // Second control line output modes
        for (int p = 0; p < 2; p++) begin
            if (desel_fall) begin
                q_nxt.desel_seen[p] = 1'b1;
            end
            if (q_nxt.ctl[p][CR_CTL2_B4]) begin
                // Manual level follows bit three
                q_nxt.c2[p] = q_nxt.ctl[p][CR_CTL2_B3];
                q_nxt.c2_pend[p] = 1'b0;
            end else if (p == 0) begin
                // First port: strobe low after data read
                if (data_rd[0]) begin
                    q_nxt.c2[0] = 1'b0;
                    q_nxt.desel_seen[0] = 1'b0;
                end else if (q_r.ctl[0][CR_CTL2_B3] && desel_fall) begin
                    q_nxt.c2[0] = 1'b1;
                end else if (!q_r.ctl[0][CR_CTL2_B3] && flag[0][1]) begin
                    q_nxt.c2[0] = 1'b1;
                end
            end else begin
                // Second port: low on the rise after a data write
                if (data_wr[1]) begin
                    q_nxt.c2_pend[1] = 1'b1;
                    q_nxt.desel_seen[1] = 1'b0;
                end
                if (en_rise && q_r.c2_pend[1]) begin
                    q_nxt.c2[1] = 1'b0;
                    q_nxt.c2_pend[1] = 1'b0;
                end else if (q_r.ctl[1][CR_CTL2_B3] && en_rise && q_r.desel_seen[1]) begin
                    q_nxt.c2[1] = 1'b1;
                    q_nxt.desel_seen[1] = 1'b0;
                end else if (!q_r.ctl[1][CR_CTL2_B3] && flag[1][1] && !q_r.c2_pend[1]) begin
                    q_nxt.c2[1] = 1'b1;
                end
            end
        end
        if (!reset_n_i) begin
            q_nxt = '0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // drivers only in selected read strobe
    assign processor_data_bus_oe_n_o = !(sel_now && read_write_i && enable_i);
    assign processor_data_bus_o = q_r.dout;

    assign irq_port_first_n_o = 1'b0;
    assign irq_port_second_n_o = 1'b0;
    assign irq_port_first_n_oe_n_o = !irq_req[0];
    assign irq_port_second_n_oe_n_o = !irq_req[1];

    assign first_port_lines_o = q_r.outr[0];
    assign first_port_lines_oe_n_o = ~q_r.dir[0];
    assign second_port_lines_o = q_r.outr[1];
    assign second_port_lines_oe_n_o = ~q_r.dir[1];

    assign first_port_ctrl_line_o = q_r.c2[0];
    assign first_port_ctrl_line_oe_n_o = !q_r.ctl[0][CR_CTL2_OUT];
    assign second_port_ctrl_line_o = q_r.c2[1];
    assign second_port_ctrl_line_oe_n_o = !q_r.ctl[1][CR_CTL2_OUT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BUS_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
        !enable_i || !read_write_i |-> processor_data_bus_oe_n_o) else $error("data bus driven outside read");

    AST_DESELECT_NO_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
        en_fall && !q_r.sel_l && reset_n_i |=> q_r.ctl == $past(q_r.ctl) && q_r.dir == $past(q_r.dir))
        else $error("deselected strobe changed a register");

    AST_WRITE_DIR: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_ev && reset_n_i && q_r.rs_l == RS_FIRST_DATA && !q_r.ctl[0][CR_DIR_ACCESS]
        |=> q_r.dir[0] == $past(q_r.din_l)) else $error("direction write lost");

    AST_WRITE_CTRL: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_ev && reset_n_i && q_r.rs_l == RS_SECOND_CTRL
        |=> q_r.ctl[1] == $past(q_r.din_l[CR_RW_BITS-1:0])) else $error("control write lost");

    AST_READ_DATA: assert property (@(posedge clock_i) disable iff (rst_i)
        enable_i && register_select_high_bit_i && !register_select_low_bit_i && q_r.ctl[1][CR_DIR_ACCESS]
        ##1 enable_i && $stable(second_port_lines_i) && $stable(q_r.outr[1]) && $stable(q_r.dir[1])
        |-> processor_data_bus_o == ((q_r.dir[1] & q_r.outr[1]) | (~q_r.dir[1] & second_port_lines_i)))
        else $error("second port read value wrong");

    AST_FIRST_READ: assert property (@(posedge clock_i) disable iff (rst_i)
        enable_i && !register_select_high_bit_i && !register_select_low_bit_i && q_r.ctl[0][CR_DIR_ACCESS]
        ##1 enable_i && $stable(first_port_lines_i) |-> processor_data_bus_o == first_port_lines_i)
        else $error("first port read is not the pin level");

    AST_RESET_PIN: assert property (@(posedge clock_i) disable iff (rst_i)
        !reset_n_i |=> q_r.ctl == '0 && q_r.dir == '0 && q_r.outr == '0 && irq_port_first_n_oe_n_o
        ##1 flag == '0) else $error("reset pin left state");

    AST_IRQ_LOW: assert property (@(posedge clock_i) disable iff (rst_i)
        flag[0][1] && q_r.ctl[0][CR_INT1_EN] |-> !irq_port_first_n_oe_n_o && !irq_port_first_n_o)
        else $error("enabled flag gave no request");

    AST_FLAG_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
        data_rd[1] ##1 !$rose(flag[1][1]) |-> !flag[1][1]) else $error("data read did not clear flag");

    AST_PORT_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        $changed(q_r.outr[1]) |-> second_port_lines_o == q_r.outr[1] && (second_port_lines_oe_n_o == ~q_r.dir[1]))
        else $error("second port drive mismatch");

endmodule // dpa_adapter

/* File: testbench/dpa_periph_model.sv */
// Purpose: Peripheral side of the adapter, with pull-ups and loading
// Assumes: Bench chooses the levels that the peripherals drive
// Notes: Load mask drags driven-high lines low to show pin read-back
`timescale 1ns/1ns
module dpa_periph_model
    import dpa_pkg::*;
(
    input wire logic [7:0] ext_a_i,
    input wire logic [7:0] ext_b_i,
    input wire logic [7:0] load_i,
    input wire logic [7:0] a_o_i,
    input wire logic [7:0] a_oe_n_i,
    input wire logic [7:0] b_o_i,
    input wire logic [7:0] b_oe_n_i,
    input wire logic irq1_oe_n_i,
    input wire logic irq2_oe_n_i,
    input wire logic irq1_n_i,
    input wire logic irq2_n_i,
    output logic [7:0] a_wire_o,
    output logic [7:0] b_wire_o,
    output logic irq1_o,
    output logic irq2_o
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    // heavy load on outputs
    assign a_wire_o = (a_oe_n_i & ext_a_i) | (~a_oe_n_i & a_o_i & ~load_i);
    assign b_wire_o = (b_oe_n_i & ext_b_i) | (~b_oe_n_i & b_o_i & ~load_i);
    assign irq1_o = irq1_oe_n_i ? 1'b1 : irq1_n_i;
    assign irq2_o = irq2_oe_n_i ? 1'b1 : irq2_n_i;
endmodule // dpa_periph_model

/* File: testbench/dpa_adapter_tb_top.sv */
// Purpose: Self-checking bench of the dual parallel port adapter
// Assumes: Bench acts as processor and drives interrupt lines
// Notes: Reads queue expected bytes; a monitor compares at read end
`timescale 1ns/1ns
module dpa_adapter_tb_top;
    import dpa_pkg::*;
    localparam logic [1:0] RSD [2] = '{RS_FIRST_DATA, RS_SECOND_DATA};
    localparam logic [1:0] RSC [2] = '{RS_FIRST_CTRL, RS_SECOND_CTRL};
    logic clock_i = 0, rst_i = 1, rstn = 0, cs_a = 0, cs_b = 0, cs_l = 1, rs_l = 0, rs_h = 0, rw = 1, en = 0;
    logic int1 = 0, int2 = 1, c2a = 0, c2b = 0, doe, i1oe, i2oe, irq1, irq2, c2aoe, prev_oe;
    logic [7:0] wd = 8'h00, ext_a = 8'h00, ext_b = 8'h00, load = 8'h00, dout, aw, bw, ao, aoe, bo, boe;
    logic i1o, i2o, c2ao, c2bo, c2boe;
    logic [7:0] dir [2], outr [2];
    logic [7:0] q [$];
    logic [15:0] lfsr_st = 16'h830B;
    int err_count = 0, n_compared = 0;
    always #50 clock_i = ~clock_i;
    dpa_adapter DUT (.clock_i(clock_i), .rst_i(rst_i), .reset_n_i(rstn), .chip_select_high_a_i(cs_a),
        .chip_select_high_b_i(cs_b), .chip_select_low_i(cs_l), .register_select_low_bit_i(rs_l),
        .register_select_high_bit_i(rs_h), .read_write_i(rw), .enable_i(en), .processor_data_bus_i(wd),
        .processor_data_bus_o(dout), .processor_data_bus_oe_n_o(doe), .irq_port_first_n_o(i1o),
        .irq_port_first_n_oe_n_o(i1oe), .irq_port_second_n_o(i2o), .irq_port_second_n_oe_n_o(i2oe),
        .first_port_lines_i(aw), .first_port_lines_o(ao), .first_port_lines_oe_n_o(aoe),
        .second_port_lines_i(bw), .second_port_lines_o(bo), .second_port_lines_oe_n_o(boe),
        .first_port_int_input_i(int1), .second_port_int_input_i(int2), .first_port_ctrl_line_i(c2a),
        .first_port_ctrl_line_o(c2ao), .first_port_ctrl_line_oe_n_o(c2aoe), .second_port_ctrl_line_i(c2b),
        .second_port_ctrl_line_o(c2bo), .second_port_ctrl_line_oe_n_o(c2boe));
    dpa_periph_model PM (.ext_a_i(ext_a), .ext_b_i(ext_b), .load_i(load), .a_o_i(ao), .a_oe_n_i(aoe),
        .b_o_i(bo), .b_oe_n_i(boe), .irq1_oe_n_i(i1oe), .irq2_oe_n_i(i2oe), .a_wire_o(aw), .b_wire_o(bw),
        .irq1_n_i(i1o), .irq2_n_i(i2o),
        .irq1_o(irq1), .irq2_o(irq2));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st[7:0];
    endfunction
    function automatic logic [7:0] pexp(input int p);
        logic [7:0] e;
        e = p ? ext_b : ext_a;
        // Loading only spoils first-port read-back
        return (~dir[p] & e) | (dir[p] & outr[p] & (p ? 8'hFF : ~load));
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #10;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // selects held through strobe; bad bits spoil one chip select
    task automatic bus(input logic r, input logic [1:0] rs, input logic [7:0] d, input logic [2:0] bad);
        {cs_a, cs_b, cs_l} = {~bad[2], ~bad[1], bad[0]};
        {rs_h, rs_l} = rs;
        rw = r;
        wd = d;
        en = 1'b1;
        if (r && bad == 3'h0) q.push_back(d);
        step(1);
        check({7'h00, doe}, {7'h00, !(r && bad == 3'h0)});
        step(1);
        en = 1'b0;
        step(2);
    endtask
    task automatic port_case(input int p);
        dir[p] = rnd();
        outr[p] = rnd();
        bus(0, RSC[p], 8'h00, 3'h0);
        bus(0, RSD[p], dir[p], 3'h0);
        bus(1, RSD[p], dir[p], 3'h0);
        bus(0, RSC[p], 8'h04, 3'h0);
        bus(0, RSD[p], outr[p], 3'h0);
        ext_a = rnd();
        ext_b = rnd();
        load = rnd();
        step(1);
        check(p ? boe : aoe, ~dir[p]);
        check(p ? bo : ao, outr[p]);
        bus(1, RSD[p], pexp(p), 3'h0);
    endtask
    // ----------------------------------------
    // Checking and stimulus
    // ----------------------------------------
    always @(negedge clock_i) begin
        prev_oe <= doe;
        if (prev_oe === 1'b0 && doe === 1'b1) check(dout, q.size() ? q.pop_front() : 8'hXX);
    end
    initial begin
        step(5000);
        err_count++;
        test_done;
    end
    initial begin
        step(20);
        rst_i = 1'b0;
        step(2);
        rstn = 1'b1;
        step(RESET_RECOVERY_CYC);
        bus(1, RS_FIRST_CTRL, 8'h00, 3'h0);
        bus(1, RS_SECOND_CTRL, 8'h00, 3'h0);
        check(aoe & boe, 8'hFF);
        $display("test reset done");
        for (int i = 0; i < 8; i++) port_case(i % 2);
        $display("test ports done");
        bus(0, RS_FIRST_CTRL, 8'hFF, 3'h0);
        bus(1, RS_FIRST_CTRL, 8'h3F, 3'h0);
        check({7'h00, c2aoe}, 8'h00);
        bus(0, RS_FIRST_CTRL, 8'h07, 3'h0);
        for (int i = 0; i < 3; i++) bus(0, RS_FIRST_CTRL, 8'h00, 3'(1 << i));
        bus(1, RS_FIRST_CTRL, 8'h07, 3'h0);
        $display("test select done");
        bus(1, RS_FIRST_CTRL, 8'h00, 3'h1);
        int1 = 1'b1;
        step(3);
        check({7'h00, irq1}, 8'h00);
        bus(1, RS_FIRST_CTRL, 8'h87, 3'h0);
        bus(1, RS_FIRST_DATA, pexp(0), 3'h0);
        step(1);
        check({7'h00, irq1}, 8'h01);
        int1 = 1'b0;
        bus(1, RS_FIRST_CTRL, 8'h07, 3'h0);
        int1 = 1'b1;
        step(3);
        check({7'h00, irq1}, 8'h01);
        int1 = 1'b0;
        bus(1, RS_FIRST_CTRL, 8'h00, 3'h4);
        int1 = 1'b1;
        step(3);
        check({7'h00, irq1}, 8'h00);
        bus(1, RS_FIRST_DATA, pexp(0), 3'h0);
        bus(0, RS_SECOND_CTRL, 8'h1C, 3'h0);
        bus(1, RS_SECOND_CTRL, 8'h00, 3'h2);
        int2 = 1'b0;
        step(3);
        check({6'h00, c2boe, irq2}, 8'h03);
        bus(1, RS_SECOND_CTRL, 8'h9C, 3'h0);
        c2b = 1'b1;
        step(3);
        check({7'h00, irq2}, 8'h00);
        bus(1, RS_SECOND_CTRL, 8'hDC, 3'h0);
        bus(1, RS_SECOND_DATA, pexp(1), 3'h0);
        bus(1, RS_SECOND_CTRL, 8'h1C, 3'h0);
        $display("test irq done");
        // handshake output: high on first-line flag, low after data read
        bus(0, RS_FIRST_CTRL, 8'h26, 3'h0);
        int1 = 1'b0;
        bus(1, RS_FIRST_CTRL, 8'h00, 3'h4);
        int1 = 1'b1;
        step(3);
        check({6'h00, c2ao, c2aoe}, 8'h02);
        bus(1, RS_FIRST_DATA, pexp(0), 3'h0);
        check({6'h00, c2ao, c2aoe}, 8'h00);
        $display("test handshake done");
        // Reset pin pulse in mid-run must zero configured state
        rstn = 1'b0;
        step(2);
        rstn = 1'b1;
        step(RESET_RECOVERY_CYC);
        check({2'h0, c2ao, c2bo, c2aoe, c2boe, irq1, irq2}, 8'h0F);
        check(aoe & boe, 8'hFF);
        bus(1, RS_FIRST_CTRL, 8'h00, 3'h0);
        bus(1, RS_SECOND_CTRL, 8'h00, 3'h0);
        $display("test reset pin done");
        test_done;
    end
endmodule // dpa_adapter_tb_top
